// ---- hw/thc_pkg.sv ----
package thc_pkg;
  // Control key codes (octal)
  localparam logic [7:0] KEY_HALT        = 8'h05;  // 05 octal
  localparam logic [7:0] KEY_START       = 8'h01;
  localparam logic [7:0] KEY_MODEM_WRITE = 8'h10;  // 20 octal
  localparam logic [7:0] KEY_MODEM_READ  = 8'h11;  // 21 octal
  // Procedural error code 136 octal
  localparam logic [7:0] ERR_POOL_BUSY   = 8'h5E;
  localparam logic [7:0] TRIB_GLOBAL     = 8'h00;
  localparam int         NTRIB           = 16;
  localparam int         TA_W            = 4;
  localparam int         POOL_W          = 4;
  localparam logic [7:0] MODEM_RESET     = 8'h00;
  localparam logic [7:0] SLOT_RESET      = 8'h00;
  // Register offsets
  localparam logic [3:0] ADDR_CMD        = 4'h0;
  localparam logic [3:0] ADDR_TRIB       = 4'h1;
  localparam logic [3:0] ADDR_MODEM      = 4'h2;
  localparam logic [3:0] ADDR_RESP       = 4'h3;
  localparam logic [3:0] ADDR_STATUS     = 4'h4;
  localparam logic [3:0] ADDR_MASK       = 4'h5;
  localparam logic [3:0] ADDR_HALTED     = 4'h6;
  localparam logic [3:0] ADDR_POOL       = 4'h7;
  localparam logic [3:0] ADDR_STATION    = 4'h8;
  // Status bit positions
  localparam int ST_DONE = 0;
  localparam int ST_ERR  = 1;
  localparam int ST_INFO = 2;
  localparam int ST_RET  = 3;
  localparam int ST_W    = 4;
  typedef enum logic [2:0] {
    THC_IDLE   = 3'b000,
    THC_DECODE = 3'b001,
    THC_RETURN = 3'b011,
    THC_DONE   = 3'b010
  } thc_state_t;
endpackage

// ---- hw/thc_return_seq.sv ----
`timescale 1ns/1ps
// Walks a set of outstanding buffers, one return pulse per buffer
module thc_return_seq
  import thc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              start,
  input  wire logic [POOL_W-1:0] count,
  output logic                   ret_pulse,
  output logic                   busy
);
  logic [POOL_W-1:0] left_reg;
  logic [POOL_W-1:0] left_next;
  wire               active = (left_reg != '0);

  // Load count on start, decrement once per returned buffer
  assign left_next = start ? count : (active ? left_reg - 1'b1 : left_reg);
  assign busy      = active;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      left_reg  <= '0;
      ret_pulse <= 1'b0;
    end else begin
      left_reg  <= left_next;
      ret_pulse <= active;
    end
  end
endmodule

// ---- hw/thc_ctl.sv ----
`timescale 1ns/1ps
// How it works
// [R1] Key 05 halts the tributary named by the address byte and returns its buffers.
// [R2] Every outstanding buffer of the halted tributary goes back to the host.
// [R3] At a control station a halted tributary drops out of polling.
// [R4] At a tributary station halted locally, polls get no answer.
// [R5] Halting never alters the tributary status slot contents.
// [R6] Only a start-up state command clears the halt of a tributary.
// [R7] Halt with address zero returns every common pool buffer.
// [R8] Host issues global halt only while the common pool is idle.
// [R9] Global halt with pool in use reports procedural error 136 octal.
// [R10] Key 20 copies the modem data byte into the modem register.
// [R11] Key 21 posts the modem register in the response word.
// [R12] One command finishes fully before the next is accepted.
module thc_ctl
  import thc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic [3:0]       addr,
  input  wire logic [7:0]       wdata,
  input  wire logic             wr,
  input  wire logic             rd,
  output logic      [15:0]      rdata,
  output logic                  irq,
  input  wire logic [NTRIB-1:0] poll_slot,
  input  wire logic [NTRIB-1:0] poll_in,
  input  wire logic [POOL_W-1:0] trib_outstanding,
  input  wire logic [POOL_W-1:0] pool_outstanding,
  input  wire logic             pool_in_use,
  input  wire logic [7:0]       slot_in,
  output logic      [NTRIB-1:0] poll_enable,
  output logic                  poll_answer,
  output logic                  buffer_return,
  output logic      [TA_W-1:0]  return_trib,
  output logic                  return_global,
  output logic      [7:0]       modem_out
);
  thc_state_t         state_reg;
  thc_state_t         state_next;
  logic [7:0]         key_reg;
  logic [7:0]         tributary_address_byte;
  logic [7:0]         modem_data_byte;
  logic [15:0]        response_word;
  logic [7:0]         modem_reg;
  logic [NTRIB-1:0]   halted_reg;
  logic [ST_W-1:0]    status_reg;
  logic [ST_W-1:0]    mask_reg;
  logic               station_ctl_reg;
  logic [7:0]         tributary_status_slot [NTRIB];
  logic               cmd_go;
  logic               seq_start;
  logic [POOL_W-1:0]  seq_count;
  logic               seq_busy;
  logic               seq_pulse;
  logic [ST_W-1:0]    st_set;
  logic               global_halt_reg;

  // Decode of the bus strobes
  wire wr_cmd     = wr && addr == ADDR_CMD;
  wire wr_trib    = wr && addr == ADDR_TRIB;
  wire wr_modem   = wr && addr == ADDR_MODEM;
  wire wr_mask    = wr && addr == ADDR_MASK;
  wire wr_station = wr && addr == ADDR_STATION;
  wire rd_status  = rd && addr == ADDR_STATUS;
  wire idle       = state_reg == THC_IDLE;
  wire [TA_W-1:0] ta = tributary_address_byte[TA_W-1:0];
  wire is_global  = tributary_address_byte == TRIB_GLOBAL;
  wire is_halt    = key_reg == KEY_HALT;
  wire is_start   = key_reg == KEY_START;
  wire is_mwrite  = key_reg == KEY_MODEM_WRITE;
  wire is_mread   = key_reg == KEY_MODEM_READ;
  wire pool_err   = is_halt && is_global && pool_in_use;  // R9
  wire in_decode  = state_reg == THC_DECODE;

  // Command is taken only when idle
  assign cmd_go = wr_cmd && idle;  // R12

  // Buffer return count: pool for global, tributary otherwise
  assign seq_start = in_decode && is_halt && !pool_err;
  assign seq_count = is_global ? pool_outstanding : trib_outstanding;  // R7

  // Next state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      THC_IDLE: begin
        if (cmd_go) begin
          state_next = THC_DECODE;
        end
      end
      THC_DECODE: begin
        if (seq_start) begin
          state_next = THC_RETURN;
        end else begin
          state_next = THC_DONE;
        end
      end
      THC_RETURN: begin
        if (!seq_busy && !seq_pulse) begin
          state_next = THC_DONE;  // R12
        end
      end
      THC_DONE: begin
        state_next = THC_IDLE;
      end
      default: begin
        state_next = THC_IDLE;
      end
    endcase
  end

  // Event sources for the sticky status
  assign st_set[ST_DONE] = state_reg == THC_DONE;
  assign st_set[ST_ERR]  = in_decode && pool_err;
  assign st_set[ST_INFO] = in_decode && is_mread;
  assign st_set[ST_RET]  = seq_pulse;

  thc_return_seq u_seq (
    .clk       (clk),
    .resetn    (resetn),
    .start     (seq_start),
    .count     (seq_count),
    .ret_pulse (seq_pulse),
    .busy      (seq_busy)
  );

  // State register of the command sequencer
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_reg <= THC_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Command key, host bytes, mask and station mode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      key_reg                <= 8'h00;
      tributary_address_byte <= 8'h00;
      modem_data_byte        <= 8'h00;
      mask_reg               <= '0;
      station_ctl_reg        <= 1'b1;
    end else begin
      if (cmd_go) key_reg <= wdata;
      if (wr_trib && idle) tributary_address_byte <= wdata;
      if (wr_modem && idle) modem_data_byte <= wdata;
      if (wr_mask) mask_reg <= wdata[ST_W-1:0];
      if (wr_station) station_ctl_reg <= wdata[0];
    end
  end

  // Modem register written by the modem write key
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modem_reg <= MODEM_RESET;
    end else if (in_decode && is_mwrite) begin
      modem_reg <= modem_data_byte;  // R10
    end
  end

  // Response word: modem value on a read key, error code on a busy pool
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      response_word <= 16'h0000;
    end else if (in_decode && is_mread) begin
      response_word <= {8'h00, modem_reg};  // R11
    end else if (st_set[ST_ERR]) begin
      response_word <= {8'h00, ERR_POOL_BUSY};  // R9
    end
  end

  // Halt flags per tributary: set by halt, cleared only by start-up
  genvar gi;
  generate
    for (gi = 0; gi < NTRIB; gi++) begin : g_trib
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          halted_reg[gi] <= 1'b0;
        end else begin
          if (in_decode && is_halt && !is_global && ta == gi) begin
            halted_reg[gi] <= 1'b1;  // R1
          end else if (in_decode && is_start && ta == gi) begin
            halted_reg[gi] <= 1'b0;  // R6
          end
        end
      end

      // Slot follows the link only while running; halt keeps it
      always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
          tributary_status_slot[gi] <= SLOT_RESET;
        end else begin
          if (!halted_reg[gi] && poll_slot[gi]) begin
            tributary_status_slot[gi] <= slot_in;  // R5
          end
        end
      end
    end
  endgenerate

  // Interrupt status next value: set wins over read clear
  wire [ST_W-1:0] status_next = (rd_status ? '0 : status_reg) | st_set;

  // Sticky status register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_reg <= '0;
    end else begin
      status_reg <= status_next;
    end
  end

  // Global flag latched at decode
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      global_halt_reg <= 1'b0;
    end else if (seq_start) begin
      global_halt_reg <= is_global;
    end
  end

  // Read words, one per register index
  wire [15:0] word_key    = {8'h00, key_reg};
  wire [15:0] word_trib   = {8'h00, tributary_address_byte};
  wire [15:0] word_modem  = {8'h00, modem_reg};
  wire [15:0] word_status = {12'h000, status_reg};
  wire [15:0] word_mask   = {12'h000, mask_reg};
  wire [15:0] word_halted = halted_reg;
  wire [15:0] word_idle   = {15'h0000, idle};
  wire [15:0] word_slot   = {8'h00, tributary_status_slot[ta]};

  // Read selection by register index; unmapped indices read zero
  wire [15:0] rd_mux = (addr == ADDR_CMD)     ? word_key      :
                       (addr == ADDR_TRIB)    ? word_trib     :
                       (addr == ADDR_MODEM)   ? word_modem    :
                       (addr == ADDR_RESP)    ? response_word :
                       (addr == ADDR_STATUS)  ? word_status   :
                       (addr == ADDR_MASK)    ? word_mask     :
                       (addr == ADDR_HALTED)  ? word_halted   :
                       (addr == ADDR_POOL)    ? word_idle     :
                       (addr == ADDR_STATION) ? word_slot     :
                                                16'h0000;

  // Next read data and interrupt level
  wire [15:0]      rdata_next         = rd ? rd_mux : 16'h0000;  // R11
  wire             irq_next           = |(status_reg & mask_reg);

  // Next poll outputs and return scope; the scope flag rides only on a return
  wire [NTRIB-1:0] poll_enable_next   = station_ctl_reg ? ~halted_reg : '0;  // R3
  wire             poll_answer_next   = !station_ctl_reg && poll_in[ta] && !halted_reg[ta];  // R4
  wire             return_global_next = global_halt_reg && seq_pulse;  // R7

  // Read data stand only in the cycle after the strobe
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 16'h0000;
    end else begin
      rdata <= rdata_next;
    end
  end

  // Level interrupt from the unmasked sticky bits
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq <= 1'b0;
    end else begin
      irq <= irq_next;
    end
  end

  // Poll enables at a control station, poll answer at a tributary station
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      poll_enable <= '0;
      poll_answer <= 1'b0;
    end else begin
      poll_enable <= poll_enable_next;  // R3
      poll_answer <= poll_answer_next;  // R4
    end
  end

  // One pulse per returned buffer, with its tributary and scope
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      buffer_return <= 1'b0;
      return_trib   <= '0;
      return_global <= 1'b0;
    end else begin
      buffer_return <= seq_pulse;  // R2
      return_trib   <= ta;
      return_global <= return_global_next;  // R7
    end
  end

  // Modem lines follow the modem register
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      modem_out <= MODEM_RESET;
    end else begin
      modem_out <= modem_reg;  // R10
    end
  end
endmodule

// ---- sim/thc_chk.sv ----
`timescale 1ns/1ps
// Port-level checks on command timing, returns, polling and modem path
module thc_chk
  import thc_pkg::*;
(
  input wire logic             clk,
  input wire logic             resetn,
  input wire logic [3:0]       addr,
  input wire logic [7:0]       wdata,
  input wire logic             wr,
  input wire logic             rd,
  input wire logic [15:0]      rdata,
  input wire logic [NTRIB-1:0] poll_in,
  input wire logic             pool_in_use,
  input wire logic [NTRIB-1:0] poll_enable,
  input wire logic             poll_answer,
  input wire logic             buffer_return,
  input wire logic             return_global,
  input wire logic [7:0]       modem_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // Key writes that the checks hang off
  wire hw = wr && addr == ADDR_CMD && wdata == KEY_HALT;
  wire mw = wr && addr == ADDR_CMD && wdata == KEY_MODEM_WRITE;
  logic [7:0] since_halt;
  logic [7:0] since_mw;
  logic [7:0] ret_cnt;
  // Cycles since the last halt or modem key, returns since halt
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      since_halt <= 8'hFF;
      since_mw <= 8'hFF;
      ret_cnt <= 8'h00;
    end else begin
      since_halt <= hw ? 8'h00 : since_halt + {7'h00, since_halt != 8'hFF};
      since_mw <= mw ? 8'h00 : since_mw + {7'h00, since_mw != 8'hFF};
      ret_cnt <= hw ? 8'h00 : ret_cnt + {7'h00, buffer_return};
    end
  end
  chk_rdata_slot: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data outside its slot");
  chk_global_pair: assert property (return_global |-> buffer_return)
    else $error("global flag without return");
  chk_pool_busy: assert property (return_global |-> !pool_in_use)
    else $error("pool returned while in use");
  chk_poll_cause: assert property (poll_answer |-> $past(|poll_in))
    else $error("poll answered without a poll");
  chk_poll_mode: assert property (poll_answer |-> poll_enable == '0)
    else $error("answer while polling as control");
  chk_modem_cause: assert property ($changed(modem_out) |-> since_mw < 8'd6)
    else $error("modem output moved without write key");
  chk_ret_cause: assert property (buffer_return |-> since_halt < 8'd24)
    else $error("buffer return without halt");
  chk_ret_count: assert property (buffer_return |-> ret_cnt < 8'd15)
    else $error("too many returns for one halt");
endmodule
bind thc_ctl thc_chk i_chk (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .poll_in, .pool_in_use,
  .poll_enable, .poll_answer, .buffer_return, .return_global, .modem_out);

// ---- sim/thc_link_model.sv ----
`timescale 1ns/1ps
// Far side holding buffers; one less per buffer handed back
module thc_link_model
  import thc_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              resetn,
  input  wire logic              set,
  input  wire logic [POOL_W-1:0] n_trib,
  input  wire logic [POOL_W-1:0] n_pool,
  input  wire logic              buffer_return,
  input  wire logic              return_global,
  output logic      [POOL_W-1:0] trib_outstanding,
  output logic      [POOL_W-1:0] pool_outstanding
);
  // Load on request, count down on returns
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      trib_outstanding <= '0;
      pool_outstanding <= '0;
    end else if (set) begin
      trib_outstanding <= n_trib;
      pool_outstanding <= n_pool;
    end else if (buffer_return && return_global) begin
      pool_outstanding <= pool_outstanding - 1'b1;
    end else if (buffer_return) begin
      trib_outstanding <= trib_outstanding - 1'b1;
    end
  end
endmodule

// ---- sim/tributary_halt_modem_ctl_cmds_tb.sv ----
`timescale 1ns/1ps
module tributary_halt_modem_ctl_cmds_tb
  import thc_pkg::*;
;
  logic              clk = 1'b0;
  logic              resetn = 1'b0;
  logic [3:0]        addr = 4'h0;
  logic [7:0]        wdata = 8'h00;
  logic              wr = 1'b0;
  logic              rd = 1'b0;
  logic              pool_in_use = 1'b0;
  logic              set = 1'b0;
  logic [NTRIB-1:0]  poll_slot = '0;
  logic [NTRIB-1:0]  poll_in = '0;
  logic [POOL_W-1:0] n_trib = '0;
  logic [POOL_W-1:0] n_pool = '0;
  logic [7:0]        slot_in = 8'h00;
  logic [15:0]       rdata, d;
  logic [NTRIB-1:0]  poll_enable;
  logic [POOL_W-1:0] trib_outstanding, pool_outstanding;
  logic [TA_W-1:0]   return_trib;
  logic [7:0]        modem_out;
  logic              irq, poll_answer, buffer_return, return_global;
  int                fails = 0;
  int                check_count = 0;
  always #5 clk = ~clk;
  thc_ctl i_dut (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .irq, .poll_slot, .poll_in, .trib_outstanding,
    .pool_outstanding, .pool_in_use, .slot_in, .poll_enable, .poll_answer, .buffer_return, .return_trib,
    .return_global, .modem_out);
  thc_link_model i_link (.clk, .resetn, .set, .n_trib, .n_pool, .buffer_return, .return_global,
    .trib_outstanding, .pool_outstanding);
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s exp %h seen %h", n, e, s);
    end
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  // Write a key, then poll the idle flag under a bound
  task cmd(input logic [7:0] k);
    wreg(ADDR_CMD, k);
    d = 16'h0000;
    for (int i = 0; i < 40 && d[0] !== 1'b1; i++) rreg(ADDR_POOL);
    chk("idle", d[0], 1'b1);
  endtask
  // Far-side stimulus: polls, slot updates, buffer counts, pool use
  task drive(input logic [NTRIB-1:0] p, s, input logic [7:0] v, input logic [3:0] t, q, input logic u);
    @(posedge clk);
    poll_in <= p;
    poll_slot <= s;
    slot_in <= v;
    n_trib <= t;
    n_pool <= q;
    pool_in_use <= u;
    set <= 1'b1;
    @(posedge clk);
    poll_in <= '0;
    poll_slot <= '0;
    set <= 1'b0;
    #1;
  endtask
  task end_sim;
    $display("checks %0d fails %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Watchdog well beyond the expected run
  initial begin
    #50000;
    fails++;
    end_sim;
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    // Modem write and read, interrupt raised, masked, cleared
    wreg(ADDR_MASK, 8'h01);
    wreg(ADDR_MODEM, 8'hA5);
    cmd(KEY_MODEM_WRITE);
    chk("modem", modem_out, 8'hA5);
    chk("irq", irq, 1'b1);
    rreg(ADDR_STATUS);
    chk("done", d[ST_DONE], 1'b1);
    rreg(ADDR_STATUS);
    chk("cleared", d[ST_DONE], 1'b0);
    cmd(KEY_MODEM_READ);
    wreg(ADDR_MASK, 8'h00);
    rreg(ADDR_RESP);
    chk("masked", irq, 1'b0);
    chk("resp", d[7:0], 8'hA5);
    rreg(ADDR_STATUS);
    chk("info", d[ST_INFO], 1'b1);
    rreg(4'hF);
    chk("unmapped", d, 16'h0000);
    // Halt tributary 3 with five buffers, writes while busy ignored
    wreg(ADDR_TRIB, 8'h03);
    drive('0, 16'h0008, 8'h42, 4'h5, 4'h0, 1'b0);
    wreg(ADDR_CMD, KEY_HALT);
    wreg(ADDR_MODEM, 8'h3C);
    cmd(KEY_MODEM_WRITE);
    chk("trib left", trib_outstanding, 4'h0);
    chk("modem kept", modem_out, 8'hA5);
    chk("ret trib", return_trib, 4'h3);
    rreg(ADDR_HALTED);
    chk("halted", d[3], 1'b1);
    chk("poll en", poll_enable[4:2], 3'b101);
    drive('0, 16'h0008, 8'h99, 4'h0, 4'h0, 1'b0);
    rreg(ADDR_STATION);
    chk("slot", d[7:0], 8'h42);
    cmd(KEY_START);
    rreg(ADDR_HALTED);
    chk("restart", d[3], 1'b0);
    chk("repoll", poll_enable[3], 1'b1);
    // Global halt, first with the pool busy
    wreg(ADDR_TRIB, TRIB_GLOBAL);
    drive('0, '0, 8'h00, 4'h0, 4'h3, 1'b1);
    cmd(KEY_HALT);
    chk("pool kept", pool_outstanding, 4'h3);
    rreg(ADDR_RESP);
    chk("err code", d[7:0], ERR_POOL_BUSY);
    rreg(ADDR_STATUS);
    chk("err bit", d[ST_ERR], 1'b1);
    chk("ret bit", d[ST_RET], 1'b1);
    drive('0, '0, 8'h00, 4'h0, 4'h3, 1'b0);
    cmd(KEY_HALT);
    chk("pool left", pool_outstanding, 4'h0);
    // Tributary station: answer polls until halted locally
    wreg(ADDR_STATION, 8'h00);
    wreg(ADDR_TRIB, 8'h05);
    drive(16'h0020, '0, 8'h00, 4'h0, 4'h0, 1'b0);
    chk("answer", poll_answer, 1'b1);
    chk("no poll", poll_enable, 16'h0000);
    cmd(KEY_HALT);
    drive(16'h0020, '0, 8'h00, 4'h0, 4'h0, 1'b0);
    chk("silent", poll_answer, 1'b0);
    end_sim;
  end
endmodule
